//--- tlih_defs.svh
`ifndef TLIH_DEFS_SVH
`define TLIH_DEFS_SVH
// ****************************************
// register byte offsets
// ****************************************
`define TLIH_OFF_EN_SET      12'h000
`define TLIH_OFF_EN_CLR      12'h004
`define TLIH_OFF_PEND_SET    12'h008
`define TLIH_OFF_PEND_CLR    12'h00c
`define TLIH_OFF_ACTIVE      12'h010
`define TLIH_OFF_MISS        12'h014
`define TLIH_OFF_PRIO_BASE   12'h100
`define TLIH_OFF_MASK_BASE   12'h200
`define TLIH_OFF_FLAG_BASE   12'h300
`define TLIH_OFF_CLAIM       12'h400
`define TLIH_OFF_DONE        12'h404
// ****************************************
// positions and reset values
// ****************************************
`define TLIH_FIRST_POS       6'd16
`define TLIH_PRIO_RESET      5'h00
`define TLIH_NONE_ID         6'h3f
`define TLIH_RESP_OKAY       2'b00
`define TLIH_RESP_SLVERR     2'b10
`endif

//--- tlih_pkg.sv
package tlih_pkg;
   typedef logic [4:0] tlih_prio_type;
   typedef logic [5:0] tlih_pos_type;
endpackage

//--- tlih_top.sv
`timescale 1ns/100ps
`include "tlih_defs.svh"
module tlih_top #(
   parameter int NUM_IRQ = 17,
   parameter int EV_W    = 16
) (
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   // axi4-lite write address
   input  wire logic [11:0]                s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   // axi4-lite write response
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   // axi4-lite read address
   input  wire logic [11:0]                s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   // axi4-lite read data
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   // peripheral event sources, one pulse or level per event bit
   input  wire logic [NUM_IRQ*EV_W-1:0]    event_in,
   // direct level lines of peripherals without second level
   input  wire logic [NUM_IRQ-1:0]         direct_irq,
   input  wire logic [NUM_IRQ-1:0]         has_events,
   // core exception side
   input  wire logic                       sys_reset_req,
   input  wire logic                       nmi_req,
   input  wire logic                       hard_fault_req,
   output tlih_pkg::tlih_pos_type          exc_id,
   output logic                            exc_valid
);
   import tlih_pkg::*;

   // ****************************************
   // state
   // ****************************************
   logic [NUM_IRQ-1:0] irq_enable;
   logic [NUM_IRQ-1:0] irq_pend;
   logic [NUM_IRQ-1:0] irq_active;
   logic [NUM_IRQ-1:0] irq_miss;
   logic [EV_W-1:0]    event_mask  [NUM_IRQ];
   logic [EV_W-1:0]    event_flags [NUM_IRQ];
   tlih_prio_type      irq_prio    [NUM_IRQ];

   // ****************************************
   // axi4-lite slave
   // ****************************************
   logic [11:0] aw_addr;
   logic        aw_held;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        w_held;
   logic        ar_busy;
   wire         wr_go    = aw_held && w_held && !s_axi_bvalid;
   wire  [31:0] wr_mask  = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
   wire  [31:0] wr_ones  = w_data & wr_mask;   // only written ones act
   wire  [NUM_IRQ-1:0] wr_bits = wr_ones[NUM_IRQ-1:0];

   // address decode helper, used by both channels
   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction
   function automatic logic in_bank(input logic [11:0] a, input logic [11:0] base);
      in_bank = (a[11:8] == base[11:8]) && (a[7:2] < 6'(NUM_IRQ)) && (a[1:0] == 2'b00);
   endfunction

   wire w_en_set   = wr_go && hit(aw_addr, `TLIH_OFF_EN_SET);
   wire w_en_clr   = wr_go && hit(aw_addr, `TLIH_OFF_EN_CLR);
   wire w_pend_set = wr_go && hit(aw_addr, `TLIH_OFF_PEND_SET);
   wire w_pend_clr = wr_go && hit(aw_addr, `TLIH_OFF_PEND_CLR);
   wire w_miss     = wr_go && hit(aw_addr, `TLIH_OFF_MISS);
   wire w_done     = wr_go && hit(aw_addr, `TLIH_OFF_DONE);
   wire w_prio     = wr_go && in_bank(aw_addr, `TLIH_OFF_PRIO_BASE);
   wire w_mask     = wr_go && in_bank(aw_addr, `TLIH_OFF_MASK_BASE);
   wire w_flag     = wr_go && in_bank(aw_addr, `TLIH_OFF_FLAG_BASE);
   wire w_ro       = wr_go && (hit(aw_addr, `TLIH_OFF_ACTIVE) || hit(aw_addr, `TLIH_OFF_CLAIM));
   wire w_ok       = w_en_set | w_en_clr | w_pend_set | w_pend_clr | w_miss | w_done
                     | w_prio | w_mask | w_flag | w_ro;
   wire [4:0] w_idx = aw_addr[6:2];

   assign s_axi_awready = !aw_held;
   assign s_axi_wready  = !w_held;

   // write channel capture, address and data in either order
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 12'h000;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `TLIH_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_held) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= w_ok ? `TLIH_RESP_OKAY : `TLIH_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ****************************************
   // second level: flags, masks, missed events
   // ****************************************
   logic [NUM_IRQ-1:0] ev_req;
   logic [NUM_IRQ-1:0] ev_miss_hit;
   always_comb begin
      for (int p = 0; p < NUM_IRQ; p++) begin
         ev_req[p]      = |(event_flags[p] & event_mask[p]);
         ev_miss_hit[p] = |(event_in[p*EV_W +: EV_W] & event_flags[p] & event_mask[p]);
      end
   end

   // flags: set wins over clear so a recurring event survives the ack
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int p = 0; p < NUM_IRQ; p++) begin
            event_flags[p] <= '0;
            event_mask[p]  <= '0;
         end
      end else begin
         for (int p = 0; p < NUM_IRQ; p++) begin
            if (w_mask && w_idx == 5'(p))
               event_mask[p] <= (event_mask[p] & ~wr_mask[EV_W-1:0])
                                | (w_data[EV_W-1:0] & wr_mask[EV_W-1:0]);
            event_flags[p] <= (event_flags[p]
                              & ~((w_flag && w_idx == 5'(p)) ? wr_ones[EV_W-1:0] : '0))
                              | event_in[p*EV_W +: EV_W];
         end
      end
   end

   // missed register, hardware set beats software clear
   always_ff @(posedge clk) begin
      if (!rst_n)
         irq_miss <= '0;
      else
         irq_miss <= (irq_miss & ~(w_miss ? wr_bits : '0)) | ev_miss_hit;
   end

   // ****************************************
   // top level: level request, pend latch, enable
   // ****************************************
   // level lines: a still-high request re-pends after a clear, hence flags first
   wire [NUM_IRQ-1:0] irq_level = (has_events & ev_req) | (~has_events & direct_irq);
   logic [NUM_IRQ-1:0] claim_bits;
   logic [NUM_IRQ-1:0] done_bits;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq_enable <= '0;
         irq_pend   <= '0;
         irq_active <= '0;
      end else begin
         irq_enable <= (irq_enable | (w_en_set ? wr_bits : '0))
                       & ~(w_en_clr ? wr_bits : '0);
         irq_pend   <= ((irq_pend | (w_pend_set ? wr_bits : '0))
                       & ~(w_pend_clr ? wr_bits : '0)
                       & ~claim_bits) | irq_level;
         irq_active <= (irq_active & ~done_bits) | claim_bits;
      end
   end

   // ****************************************
   // priority arbitration
   // ****************************************
   wire [NUM_IRQ-1:0] irq_ready = irq_pend & irq_enable;
   logic [5:0]        best_n;
   tlih_prio_type     best_p;
   logic              best_v;
   // strict less-than keeps the lowest index on ties
   always_comb begin
      best_n = 6'h00;
      best_p = 5'h1f;
      best_v = 1'b0;
      for (int n = 0; n < NUM_IRQ; n++) begin
         if (irq_ready[n] && (!best_v || irq_prio[n] < best_p)) begin
            best_v = 1'b1;
            best_p = irq_prio[n];
            best_n = 6'(n);
         end
      end
   end

   // fixed exceptions bypass the software levels entirely
   wire          fixed_v  = sys_reset_req | nmi_req | hard_fault_req;
   wire [5:0]    fixed_id = sys_reset_req ? 6'd1 : (nmi_req ? 6'd2 : 6'd3);
   wire [5:0]    next_id  = fixed_v ? fixed_id
                          : (best_v ? best_n + `TLIH_FIRST_POS : `TLIH_NONE_ID);
   // claim strobe sits here so arbitration and read data share one decode
   wire          rd_go       = s_axi_arvalid && !ar_busy;
   wire          rd_claim_go = rd_go && hit(s_axi_araddr, `TLIH_OFF_CLAIM);
   wire          claim_go    = rd_claim_go && best_v && !fixed_v;

   always_comb begin
      claim_bits = '0;
      done_bits  = '0;
      if (claim_go)
         claim_bits[best_n[4:0]] = 1'b1;
      if (w_done)
         done_bits = wr_bits;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         exc_id    <= `TLIH_NONE_ID;
         exc_valid <= 1'b0;
      end else begin
         exc_id    <= next_id;
         exc_valid <= fixed_v | best_v;
      end
   end

   // priority registers, one per line in the low five bits
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int n = 0; n < NUM_IRQ; n++)
            irq_prio[n] <= `TLIH_PRIO_RESET;
      end else if (w_prio && w_strb[0]) begin
         irq_prio[w_idx] <= w_data[4:0];
      end
   end

   // ****************************************
   // read channel
   // ****************************************
   wire [4:0]   r_idx       = s_axi_araddr[6:2];
   logic [31:0] rd_val;
   logic        rd_ok;
   // claim read hands out the winner and marks it active
   always_comb begin
      rd_val = 32'h0000_0000;
      rd_ok  = 1'b1;
      if (hit(s_axi_araddr, `TLIH_OFF_EN_SET) || hit(s_axi_araddr, `TLIH_OFF_EN_CLR))
         rd_val[NUM_IRQ-1:0] = irq_enable;
      else if (hit(s_axi_araddr, `TLIH_OFF_PEND_SET) || hit(s_axi_araddr, `TLIH_OFF_PEND_CLR))
         rd_val[NUM_IRQ-1:0] = irq_pend;
      else if (hit(s_axi_araddr, `TLIH_OFF_ACTIVE))
         rd_val[NUM_IRQ-1:0] = irq_active;
      else if (hit(s_axi_araddr, `TLIH_OFF_MISS))
         rd_val[NUM_IRQ-1:0] = irq_miss;
      else if (hit(s_axi_araddr, `TLIH_OFF_CLAIM))
         rd_val[5:0] = (best_v && !fixed_v) ? best_n + `TLIH_FIRST_POS : `TLIH_NONE_ID;
      else if (in_bank(s_axi_araddr, `TLIH_OFF_PRIO_BASE))
         rd_val[4:0] = irq_prio[r_idx];
      else if (in_bank(s_axi_araddr, `TLIH_OFF_MASK_BASE))
         rd_val[EV_W-1:0] = event_mask[r_idx];
      else if (in_bank(s_axi_araddr, `TLIH_OFF_FLAG_BASE))
         rd_val[EV_W-1:0] = event_flags[r_idx];
      else
         rd_ok = 1'b0;
   end

   assign s_axi_arready = !ar_busy;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ar_busy      <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `TLIH_RESP_OKAY;
      end else if (rd_go) begin
         ar_busy      <= 1'b1;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_val;
         s_axi_rresp  <= rd_ok ? `TLIH_RESP_OKAY : `TLIH_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         ar_busy      <= 1'b0;
         s_axi_rvalid <= 1'b0;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_flag_set_wins: assert property (event_in[5*EV_W+3] |=> event_flags[5][3])
      else $error("event flag not set by event");
   chk_fixed_first: assert property (nmi_req && !sys_reset_req |=> exc_id == 6'd2)
      else $error("nmi not served before others");
   chk_reset_top: assert property (sys_reset_req |=> exc_id == 6'd1 && exc_valid)
      else $error("reset not highest");
   chk_gate_pend: assert property (!fixed_v && (irq_pend & irq_enable) == '0 |=> !exc_valid)
      else $error("exception without pending and enabled line");
   chk_en_set: assert property (w_en_set && wr_bits[0] && !w_en_clr |=> irq_enable[0])
      else $error("enable set failed");
   chk_en_clr: assert property (w_en_clr && wr_bits[0] |=> !irq_enable[0])
      else $error("enable clear failed");
   chk_level_hold: assert property (has_events[5] && ev_req[5] |=> irq_pend[5])
      else $error("request dropped while flags enabled");
   chk_miss_set: assert property (ev_miss_hit[5] |=> irq_miss[5])
      else $error("missed event not recorded");
   chk_miss_keep: assert property (!ev_miss_hit[5] && !(w_miss && wr_bits[5]) |=> $stable(irq_miss[5]))
      else $error("missed bit changed without cause");
   chk_active_ro: assert property (w_ro |=> $stable(irq_active) || $past(claim_go))
      else $error("active changed by write");
   // top-level latch and service: software set and clear, zero writes, done, equal-priority tie
   chk_pend_set: assert property (w_pend_set && wr_bits[3] && !claim_bits[3] |=> irq_pend[3])
      else $error("pend set failed");
   chk_pend_clr: assert property (w_pend_clr && wr_bits[3] && !irq_level[3] |=> !irq_pend[3])
      else $error("pend clear failed");
   chk_pend_zero: assert property (w_pend_clr && !wr_bits[3] && irq_pend[3] && !claim_bits[3] |=> irq_pend[3])
      else $error("zero write cleared pend");
   chk_done_clear: assert property (w_done && wr_bits[2] && !claim_bits[2] |=> !irq_active[2])
      else $error("done did not end service");
   chk_tie_low: assert property (!fixed_v && irq_ready[3:0] == 4'hc && irq_ready[NUM_IRQ-1:4] == '0
      && irq_prio[2] == irq_prio[3] |=> exc_id == 6'h12)
      else $error("equal priority not resolved to lower position");
   // second level: clear, late mask and missed acknowledge
   chk_flag_clear: assert property (w_flag && w_idx == 5'd5 && wr_ones[3] && !event_in[5*EV_W+3] |=> !event_flags[5][3])
      else $error("flag not cleared by one");
   chk_mask_prop: assert property (has_events[5] && event_flags[5][3] && event_mask[5][3] |=> irq_pend[5])
      else $error("enabled flag did not reach top level");
   chk_miss_clear: assert property (w_miss && wr_bits[5] && !ev_miss_hit[5] |=> !irq_miss[5])
      else $error("missed bit not cleared by one");

   cov_fixed: cover property (nmi_req ##1 exc_id == 6'd2);
   cov_claim: cover property (claim_go ##1 irq_active != '0);
   cov_miss:  cover property (ev_miss_hit != '0);
   cov_write: cover property (wr_go && w_flag);
   cov_tie:   cover property (irq_ready[2] && irq_ready[3] && irq_prio[2] == irq_prio[3]);
endmodule // tlih_top

//--- tlih_periph_model.sv
`timescale 1ns/100ps
// ****************************************
// peripheral event sources and core side
// ****************************************
module tlih_periph_model #(
   parameter int NUM_IRQ = 17,
   parameter int EV_W    = 16
) (
   // clock
   input  wire logic                   clk,
   // request lines toward the hub
   output logic [NUM_IRQ*EV_W-1:0]     event_in,
   output logic [NUM_IRQ-1:0]          direct_irq,
   output logic                        sys_reset_req,
   output logic                        nmi_req,
   output logic                        hard_fault_req,
   // exception offered to the core
   input  wire tlih_pkg::tlih_pos_type exc_id,
   input  wire logic                   exc_valid
);
   import tlih_pkg::*;
   tlih_pos_type last_id;
   // all sources quiet until a scenario asks
   initial begin
      event_in = '0;
      direct_irq = '0;
      {sys_reset_req, nmi_req, hard_fault_req} = 3'h0;
      last_id = 6'h3f;
   end
   // core remembers the last exception it was offered
   always @(posedge clk) begin
      if (exc_valid) begin
         last_id <= exc_id;
      end
   end
   // event held n cycles; a held level repeats the event each cycle
   task automatic fire(input int idx, input int n);
      @(posedge clk);
      event_in[idx] <= 1'b1;
      repeat (n) @(posedge clk);
      event_in[idx] <= 1'b0;
   endtask
   // direct and fixed-priority lines are plain levels
   task automatic lines(input logic [NUM_IRQ-1:0] d, input logic [2:0] f);
      @(posedge clk);
      direct_irq <= d;
      {sys_reset_req, nmi_req, hard_fault_req} <= f;
   endtask
endmodule // tlih_periph_model

//--- two_level_interrupt_hub_test.sv
`timescale 1ns/100ps
`include "tlih_defs.svh"
module two_level_interrupt_hub_test;
   import tlih_pkg::*;
   // ****************************************
   // signals
   // ****************************************
   logic         clk, rst_n;
   logic [11:0]  awaddr, araddr;
   logic [31:0]  wdata, rdata, rd;
   logic [3:0]   wstrb;
   logic [1:0]   bresp, rresp, rr, br;
   logic         awvalid, awready, wvalid, wready, bvalid, bready;
   logic         arvalid, arready, rvalid, rready;
   logic [271:0] event_in;
   logic [16:0]  direct_irq;
   logic         sys_reset_req, nmi_req, hard_fault_req, exc_valid;
   tlih_pos_type exc_id;
   int           failures = 0;
   int           checked = 0;
   int           cycles = 0;
   // lines 0..3 direct, the rest fed by the second level
   tlih_top dut_u (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .event_in(event_in), .direct_irq(direct_irq), .has_events(17'h1fff0),
      .sys_reset_req(sys_reset_req), .nmi_req(nmi_req), .hard_fault_req(hard_fault_req),
      .exc_id(exc_id), .exc_valid(exc_valid));
   tlih_periph_model pm_u (.clk(clk), .event_in(event_in), .direct_irq(direct_irq),
      .sys_reset_req(sys_reset_req), .nmi_req(nmi_req), .hard_fault_req(hard_fault_req),
      .exc_id(exc_id), .exc_valid(exc_valid));
   // ****************************************
   // checking and bus tasks
   // ****************************************
   task cmp_word(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task cmp_exc(input logic [6:0] got, input logic [6:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wrap_up;
      if (failures == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // address and data offered together, each dropped once taken
   task wr(input logic [11:0] a, input logic [31:0] d);
      logic done;
      done = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) begin
            br = bresp;
            bready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask
   task rg(input logic [11:0] a);
      logic done;
      done = 1'b0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) begin
            rd = rdata;
            rr = rresp;
            rready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask
   task rc(input logic [11:0] a, input logic [31:0] exp);
      rg(a);
      cmp_word(rd, exp);
   endtask
   // exception output trails the state by a cycle; give it room
   task ex(input logic v, input tlih_pos_type id);
      repeat (3) @(posedge clk);
      cmp_exc({exc_valid, exc_id}, {v, id});
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task t_reset;
      rc(`TLIH_OFF_EN_SET, 32'h0);
      rc(`TLIH_OFF_MISS, 32'h0);
      ex(1'b0, `TLIH_NONE_ID);
      rg(12'h0f0);
      cmp_word({rd[29:0], rr}, {30'h0, `TLIH_RESP_SLVERR});
      wr(12'h0f0, 32'h1ffff);
      cmp_word({30'h0, br}, {30'h0, `TLIH_RESP_SLVERR});
      rc(`TLIH_OFF_EN_SET, 32'h0);
   endtask
   task t_mask;
      wr(`TLIH_OFF_EN_SET, 32'h5);
      cmp_word({30'h0, br}, {30'h0, `TLIH_RESP_OKAY});
      rc(`TLIH_OFF_EN_SET, 32'h5);
      wr(`TLIH_OFF_EN_CLR, 32'h1);
      rc(`TLIH_OFF_EN_CLR, 32'h4);
      wr(`TLIH_OFF_EN_SET, 32'h0);
      wr(`TLIH_OFF_EN_CLR, 32'h0);
      rc(`TLIH_OFF_EN_SET, 32'h4);
   endtask
   task t_pend;
      wr(`TLIH_OFF_PEND_SET, 32'h8);
      ex(1'b0, `TLIH_NONE_ID);
      rc(`TLIH_OFF_PEND_CLR, 32'h8);
      wr(`TLIH_OFF_EN_SET, 32'h8);
      ex(1'b1, 6'h13);
      wr(`TLIH_OFF_PEND_CLR, 32'h0);
      ex(1'b1, 6'h13);
      wr(`TLIH_OFF_PEND_CLR, 32'h8);
      ex(1'b0, `TLIH_NONE_ID);
   endtask
   task t_prio;
      wr(`TLIH_OFF_PRIO_BASE + 12'h00c, 32'h2);
      wr(`TLIH_OFF_PRIO_BASE + 12'h008, 32'h4);
      wr(`TLIH_OFF_PEND_SET, 32'hc);
      ex(1'b1, 6'h13);
      wr(`TLIH_OFF_PRIO_BASE + 12'h00c, 32'h4);
      ex(1'b1, 6'h12);
      wr(`TLIH_OFF_EN_SET, 32'h10000);
      wr(`TLIH_OFF_PEND_SET, 32'h10000);
      ex(1'b1, 6'h20);
   endtask
   task t_fixed;
      pm_u.lines(17'h0, 3'h2);
      ex(1'b1, 6'h02);
      pm_u.lines(17'h0, 3'h6);
      ex(1'b1, 6'h01);
      pm_u.lines(17'h0, 3'h1);
      ex(1'b1, 6'h03);
      cmp_word({26'h0, pm_u.last_id}, 32'h3);
      pm_u.lines(17'h0, 3'h0);
      wr(`TLIH_OFF_PEND_CLR, 32'h1ffff);
      ex(1'b0, `TLIH_NONE_ID);
   endtask
   task t_active;
      wr(`TLIH_OFF_PEND_SET, 32'h4);
      rc(`TLIH_OFF_CLAIM, 32'h12);
      rc(`TLIH_OFF_ACTIVE, 32'h4);
      wr(`TLIH_OFF_ACTIVE, 32'h1ffff);
      cmp_word({30'h0, br}, {30'h0, `TLIH_RESP_OKAY});
      rc(`TLIH_OFF_ACTIVE, 32'h4);
      wr(`TLIH_OFF_DONE, 32'h4);
      rc(`TLIH_OFF_ACTIVE, 32'h0);
   endtask
   task t_direct;
      pm_u.lines(17'h2, 3'h0);
      wr(`TLIH_OFF_EN_SET, 32'h2);
      ex(1'b1, 6'h11);
      wr(`TLIH_OFF_PEND_CLR, 32'h2);
      rc(`TLIH_OFF_PEND_CLR, 32'h2);
      pm_u.lines(17'h0, 3'h0);
      wr(`TLIH_OFF_PEND_CLR, 32'h2);
      ex(1'b0, `TLIH_NONE_ID);
   endtask
   // peripheral 5, event bits 3 and 4
   task t_events;
      wr(`TLIH_OFF_EN_SET, 32'h20);
      pm_u.fire(83, 1);
      rc(`TLIH_OFF_FLAG_BASE + 12'h014, 32'h8);
      rc(`TLIH_OFF_PEND_CLR, 32'h0);
      wr(`TLIH_OFF_MASK_BASE + 12'h014, 32'h8);
      rc(`TLIH_OFF_MASK_BASE + 12'h014, 32'h8);
      ex(1'b1, 6'h15);
      wr(`TLIH_OFF_FLAG_BASE + 12'h014, 32'h0);
      rc(`TLIH_OFF_FLAG_BASE + 12'h014, 32'h8);
      wr(`TLIH_OFF_PEND_CLR, 32'h20);
      ex(1'b1, 6'h15);
      fork
         pm_u.fire(83, 12);
         wr(`TLIH_OFF_FLAG_BASE + 12'h014, 32'h8);
      join
      rc(`TLIH_OFF_FLAG_BASE + 12'h014, 32'h8);
      rc(`TLIH_OFF_MISS, 32'h20);
      wr(`TLIH_OFF_MISS, 32'h0);
      rc(`TLIH_OFF_MISS, 32'h20);
      wr(`TLIH_OFF_MISS, 32'h20);
      rc(`TLIH_OFF_MISS, 32'h0);
      wr(`TLIH_OFF_FLAG_BASE + 12'h014, 32'h8);
      wr(`TLIH_OFF_PEND_CLR, 32'h20);
      ex(1'b0, `TLIH_NONE_ID);
      wr(`TLIH_OFF_MASK_BASE + 12'h014, 32'h0);
      rc(`TLIH_OFF_MASK_BASE + 12'h014, 32'h0);
      pm_u.fire(84, 3);
      rc(`TLIH_OFF_MISS, 32'h0);
      rc(`TLIH_OFF_FLAG_BASE + 12'h014, 32'h10);
   endtask
   // ****************************************
   // clock, timeout and main sequence
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // a hang counts as a mismatch
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         wrap_up;
      end
   end
   initial begin
      rst_n = 1'b0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hf;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_reset;
      t_mask;
      t_pend;
      t_prio;
      t_fixed;
      t_active;
      t_direct;
      t_events;
      wrap_up;
   end
endmodule // two_level_interrupt_hub_test
